// ==== sea_bus_ctl_model.sv ====
`timescale 1ns/10ps
module sea_bus_ctl_model (
    output logic      scl,
    output logic      sdaLow,
    input  wire logic sda
);
    // Quarter of the 160 ns bus period; the clock stands high between frames
    localparam int QTR = 40;

    initial begin
        scl    = 1'b1;
        sdaLow = 1'b0;
    end

    // Also serves as a repeated start from the low clock phase
    task automatic bus_start();
        sdaLow = 1'b0;
        #QTR scl = 1'b1;
        #QTR sdaLow = 1'b1;
        #QTR scl = 1'b0;
        #QTR;
    endtask

    task automatic bus_stop();
        sdaLow = 1'b1;
        #QTR scl = 1'b1;
        #QTR sdaLow = 1'b0;
        #QTR;
    endtask

    task automatic clk_bit(output logic seen);
        #QTR scl = 1'b1;
        #QTR seen = sda;
        #QTR scl = 1'b0;
        #QTR;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            sdaLow = ~b[i];
            clk_bit(s);
        end
        sdaLow = 1'b0;
        clk_bit(s);
        ack = (s === 1'b0);
    endtask

    // A released line reads back as the pull-up level
    task automatic get_byte(input logic more, output logic [7:0] d);
        logic s;
        sdaLow = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i]);
        end
        sdaLow = more;
        clk_bit(s);
    endtask
endmodule // sea_bus_ctl_model

// ==== sea_eeprom_target.sv ====
`timescale 1ns/10ps
// Overview of operation
// - Write: acknowledge word address byte with zero
// - Program cycle after stop; ignore all inputs
// - Page size 8 or 16 bytes
// - Page write: acknowledge every extra data byte
// - Write: only low page bits increment
// - Excess page bytes wrap and overwrite
// - Address acknowledged only after programming ends
// - Read selected by direction bit one
// - Counter holds last address plus one
// - Read wraps whole array; write wraps page
// - Read sends byte at counter address
// - Sequential read increments after each byte sent
// - Program cycle lasts at most 5 ms
// - Page-select bits are upper address bits
// - Acknowledge only matching device address
// - Write-protect high blocks all array writes
module sea_eeprom_target
    import sea_pkg::*;
#(
    parameter int ADDR_W    = 11,
    parameter int PAGE_W    = 4,
    parameter int PROG_CYCLES = SEA_PROG_CYC
) (
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic                 sclIn,
    input  wire logic                 sdaIn,
    output logic                      sdaOut,
    output logic                      sdaOe,
    input  wire logic [SEA_SEL_W-1:0] hardwired_select_pins,
    input  wire logic                 writeProtect,
    output logic                      programBusy
);
    localparam int SEL_ADDR = ADDR_W - SEA_BYTE_W;
    localparam int SEL_CMP  = SEA_SEL_W - SEL_ADDR;
    localparam int MEM_N    = 1 << ADDR_W;
    localparam int CW       = $clog2(PROG_CYCLES + 1);

    initial begin
        if (ADDR_W < 8 || ADDR_W > 11) $error("ADDR_W must be 8 to 11");
        if (PAGE_W != 3 && PAGE_W != 4) $error("PAGE_W must be 3 or 4");
        if (PROG_CYCLES < 1) $error("PROG_CYCLES must be positive");
    end

    typedef enum logic [2:0] {
        SEA_IDLE, SEA_DEVADDR, SEA_WORDADDR, SEA_WDATA, SEA_RDATA, SEA_RACK, SEA_SKIP
    } sea_state_t;

    sea_state_t        state_r;
    logic [2:0]        sclSync_r;
    logic [2:0]        sdaSync_r;
    logic [7:0]        shift_r;
    logic [3:0]        bitCnt_r;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] wrAddr_r;
    logic              wrPending_r;
    logic [CW-1:0]     progCnt_r;
    logic              sdaOe_r;
    logic [7:0]        txByte_r;
    logic [7:0]        mem_r [MEM_N];
    logic [SEL_ADDR > 0 ? SEL_ADDR-1 : 0:0] pageSel_r;
    logic              sclRise;
    logic              sclFall;
    logic              sclHigh;
    logic              startCond;
    logic              stopCond;
    logic [7:0]        rxByte;
    logic              addrMatch;
    logic              fifoInValid;
    logic              fifoInReady;
    logic              fifoOutValid;
    logic              fifoOutReady;
    sea_wr_t           fifoIn;
    sea_wr_t           fifoOut;
    logic [ADDR_W-1:0] pageNext;
    logic [ADDR_W-1:0] wrPageNext;
    logic [1:0]        wpSync_r;

    // Stage 0 is the synchroniser's first flop; only stage 1 and 2 are used
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sclSync_r <= 3'h7;
            sdaSync_r <= 3'h7;
        end else begin
            sclSync_r <= {sclSync_r[1:0], sclIn};
            sdaSync_r <= {sdaSync_r[1:0], sdaIn};
        end
    end

    assign sclRise   = sclSync_r[1] && !sclSync_r[2];
    assign sclFall   = !sclSync_r[1] && sclSync_r[2];
    assign sclHigh   = sclSync_r[1] && sclSync_r[2];
    assign startCond = sclHigh && !sdaSync_r[1] && sdaSync_r[2];
    assign stopCond  = sclHigh && sdaSync_r[1] && !sdaSync_r[2];
    assign rxByte    = {shift_r[6:0], sdaSync_r[1]};

    // Write protect is a pin: two flops before the write gate reads it
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wpSync_r <= 2'h0;
        end else begin
            wpSync_r <= {wpSync_r[0], writeProtect};
        end
    end

    // Densities with no strap bits left compare only the device code
    if (SEL_CMP > 0) begin : g_selCmp
        assign addrMatch = rxByte[7:4] == SEA_DEV_CODE && (rxByte[3:4-SEL_CMP] ==
                           hardwired_select_pins[SEA_SEL_W-1:SEA_SEL_W-SEL_CMP]);
    end else begin : g_noSelCmp
        assign addrMatch = rxByte[7:4] == SEA_DEV_CODE;
    end

    // Page-local increments of wrAddr_r and addr_r; reads use a whole-array increment
    assign wrPageNext = {wrAddr_r[ADDR_W-1:PAGE_W], wrAddr_r[PAGE_W-1:0] + 1'b1};
    assign pageNext   = {addr_r[ADDR_W-1:PAGE_W], addr_r[PAGE_W-1:0] + 1'b1};

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r     <= SEA_IDLE;
            bitCnt_r    <= '0;
            shift_r     <= '0;
            addr_r      <= '0;
            wrAddr_r    <= '0;
            wrPending_r <= 1'b0;
            sdaOe_r     <= 1'b0;
            txByte_r    <= '0;
            pageSel_r   <= '0;
        end else if (progCnt_r != '0) begin
            state_r <= SEA_IDLE;
            sdaOe_r <= 1'b0;
        end else if (startCond) begin
            state_r  <= SEA_DEVADDR;
            bitCnt_r <= '0;
            sdaOe_r  <= 1'b0;
        end else if (stopCond) begin
            state_r     <= SEA_IDLE;
            sdaOe_r     <= 1'b0;
            wrPending_r <= 1'b0;
        end else if (sclRise && state_r != SEA_IDLE) begin
            if (bitCnt_r == SEA_BIT_ACK) begin
                bitCnt_r <= '0;
                if (state_r == SEA_RACK) begin
                    // Controller acknowledge continues the read, no-ack ends it
                    state_r <= sdaSync_r[1] ? SEA_SKIP : SEA_RDATA;
                end
            end else begin
                shift_r  <= rxByte;
                bitCnt_r <= bitCnt_r + 1'b1;
                if (bitCnt_r == SEA_BIT_LAST) begin
                    case (state_r)
                        SEA_DEVADDR: begin
                            if (!addrMatch) begin
                                state_r <= SEA_SKIP;
                            end else if (rxByte[0]) begin
                                state_r <= SEA_RDATA;
                            end else begin
                                state_r <= SEA_WORDADDR;
                            end
                            if (SEL_ADDR > 0) pageSel_r <= rxByte[SEL_ADDR:1];
                        end
                        SEA_WORDADDR: begin
                            state_r  <= SEA_WDATA;
                            addr_r   <= ADDR_W'({pageSel_r, rxByte});
                            wrAddr_r <= ADDR_W'({pageSel_r, rxByte});
                        end
                        SEA_WDATA: begin
                            wrAddr_r    <= wrPageNext;
                            addr_r      <= wrPageNext;
                            wrPending_r <= 1'b1;
                        end
                        SEA_RDATA: begin
                            state_r <= SEA_RACK;
                            addr_r  <= addr_r + 1'b1;
                        end
                        default: state_r <= state_r;
                    endcase
                end
            end
        end else if (sclFall) begin
            // Drive on the falling edge so data is stable while clock is high
            if (bitCnt_r == SEA_BIT_LAST + 4'h1 &&
                (state_r == SEA_WORDADDR || state_r == SEA_WDATA ||
                 (state_r == SEA_RDATA && shift_r[0] == 1'b1) ||
                 state_r == SEA_RACK && 1'b0)) begin
                sdaOe_r <= state_r != SEA_RACK;
            end else if (state_r == SEA_RDATA && bitCnt_r != SEA_BIT_ACK) begin
                if (bitCnt_r == '0) begin
                    txByte_r <= {mem_r[addr_r][6:0], 1'b0};
                    sdaOe_r  <= !mem_r[addr_r][7];
                end else begin
                    txByte_r <= {txByte_r[6:0], 1'b0};
                    sdaOe_r  <= !txByte_r[7];
                end
            end else begin
                sdaOe_r <= 1'b0;
            end
        end
    end

    // Bytes of a page write are queued and drained in order, so a wrapped byte
    // always lands after the earlier byte at the same address
    assign fifoIn.addr  = 11'(wrAddr_r);
    assign fifoIn.data  = rxByte;
    assign fifoInValid  = sclRise && state_r == SEA_WDATA && bitCnt_r == SEA_BIT_LAST
                          && progCnt_r == '0 && !startCond && !stopCond && !wpSync_r[1];
    // Drain holds off only in the cycle an overflow byte uses the array port
    assign fifoOutReady = !(fifoInValid && !fifoInReady);

    sea_fifo #(
        .WIDTH ($bits(sea_wr_t)),
        .DEPTH (SEA_FIFO_DEPTH)
    ) u_fifo (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (fifoIn),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOut)
    );

    always_ff @(posedge clock) begin
        if (fifoOutValid && fifoOutReady) begin
            mem_r[fifoOut.addr[ADDR_W-1:0]] <= fifoOut.data;
        end
        // A full queue overflows straight into the array so no byte is lost
        if (fifoInValid && !fifoInReady) begin
            mem_r[wrAddr_r] <= rxByte;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            progCnt_r <= '0;
        end else if (progCnt_r != '0) begin
            progCnt_r <= progCnt_r - 1'b1;
        end else if (stopCond && wrPending_r) begin
            progCnt_r <= CW'(PROG_CYCLES);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            programBusy <= 1'b0;
        end else begin
            programBusy <= progCnt_r != '0 || (stopCond && wrPending_r);
        end
    end

    assign sdaOe  = sdaOe_r;
    assign sdaOut = 1'b0;

    progBoundLen_a: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(programBusy) |-> programBusy [*8])
        else $error("program cycle ended too early");
    progQuiet_a: assert property (@(posedge clock) disable iff (sys_rst)
        progCnt_r != '0 |=> !sdaOe_r)
        else $error("device answered during program cycle");
    progStart_a: assert property (@(posedge clock) disable iff (sys_rst)
        stopCond && wrPending_r && progCnt_r == '0 |=> progCnt_r == CW'(PROG_CYCLES))
        else $error("program cycle not started by stop");
    pageWrap_a: assert property (@(posedge clock) disable iff (sys_rst)
        fifoInValid |=> wrAddr_r[ADDR_W-1:PAGE_W] == $past(wrAddr_r[ADDR_W-1:PAGE_W]))
        else $error("page write left its page");
    protect_a: assert property (@(posedge clock) disable iff (sys_rst)
        wpSync_r[1] |-> !fifoInValid)
        else $error("write accepted while protected");
    readInc_a: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(state_r == SEA_RACK) |-> addr_r == $past(addr_r) + 1'b1)
        else $error("read counter did not advance");
    badAddr_a: assert property (@(posedge clock) disable iff (sys_rst)
        state_r == SEA_SKIP |-> !sdaOe_r ##1 !sdaOe_r)
        else $error("unmatched address acknowledged");
    wordLoad_a: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(state_r == SEA_WDATA) |-> addr_r == wrAddr_r)
        else $error("word address not loaded");
endmodule // sea_eeprom_target

// ==== sea_eeprom_target_test.sv ====
`timescale 1ns/10ps
module sea_eeprom_target_test;
    import sea_pkg::*;
    // Short program cycle, still longer than one polling frame
    localparam int PROG = 400;
    logic       clock;
    logic       sys_rst;
    logic       scl;
    logic       sdaLow;
    logic       sdaOut;
    logic       sdaOe;
    logic       writeProtect;
    logic       programBusy;
    logic [2:0] selPins;
    wire logic  sda;
    int         num_errors;
    int         n_tests;

    assign sda = (sdaLow || (sdaOe && !sdaOut)) ? 1'b0 : 1'b1;

    sea_eeprom_target #(.PROG_CYCLES(PROG)) i_sea_eeprom_target (
        .clock(clock), .sys_rst(sys_rst), .sclIn(scl), .sdaIn(sda),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .hardwired_select_pins(selPins),
        .writeProtect(writeProtect), .programBusy(programBusy));
    sea_bus_ctl_model i_m (.scl(scl), .sdaLow(sdaLow), .sda(sda));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] devb(input logic [10:0] a, input logic rd);
        return {SEA_DEV_CODE, a[10:8], rd};
    endfunction

    task automatic wr_seq(input logic [10:0] addr, input logic [7:0] d[$]);
        logic a;
        int   n;
        i_m.bus_start();
        i_m.send_byte(devb(addr, 1'b0), a);
        check("device ack", {7'h0, a}, 8'h01);
        i_m.send_byte(addr[7:0], a);
        check("word ack", {7'h0, a}, 8'h01);
        foreach (d[i]) begin
            i_m.send_byte(d[i], a);
            check("data ack", {7'h0, a}, 8'h01);
        end
        i_m.bus_stop();
        i_m.bus_start();
        i_m.send_byte(devb(addr, 1'b0), a);
        check("poll ack while busy", {7'h0, a}, 8'h00);
        check("busy", {7'h0, programBusy}, 8'h01);
        i_m.bus_stop();
        n = 0;
        while (programBusy !== 1'b0) begin
            @(posedge clock);
            n++;
            if (n > PROG) begin
                num_errors++;
                report_and_stop();
            end
        end
        @(posedge clock);
        #1;
    endtask

    // With rnd set, a dummy write loads the address, then a repeated start reads
    task automatic rd_seq(input logic rnd, input logic [10:0] addr, input int n,
                          output logic [7:0] q[$]);
        logic       a;
        logic [7:0] b;
        q = {};
        i_m.bus_start();
        if (rnd) begin
            i_m.send_byte(devb(addr, 1'b0), a);
            i_m.send_byte(addr[7:0], a);
            check("dummy word ack", {7'h0, a}, 8'h01);
            i_m.bus_start();
        end
        i_m.send_byte(devb(addr, 1'b1), a);
        check("read ack", {7'h0, a}, 8'h01);
        for (int i = 0; i < n; i++) begin
            i_m.get_byte(i < n - 1, b);
            q.push_back(b);
        end
        i_m.bus_stop();
    endtask

    task automatic test_page_wrap();
        logic [7:0] q[$];
        wr_seq(11'h0FE, '{8'h11, 8'h22, 8'h33});
        rd_seq(1'b1, 11'h0FE, 2, q);
        check("page low", q[0], 8'h11);
        check("page top", q[1], 8'h22);
        rd_seq(1'b1, 11'h0F0, 1, q);
        check("page wrapped", q[0], 8'h33);
        $display("done page wrap");
    endtask

    task automatic test_overrun();
        logic [7:0] d[$];
        logic [7:0] q[$];
        logic [7:0] exp[16];
        for (int i = 0; i < 17; i++) begin
            d.push_back(8'h40 + 8'(i));
            exp[(5 + i) % 16] = 8'h40 + 8'(i);
        end
        wr_seq(11'h125, d);
        rd_seq(1'b1, 11'h120, 15, q);
        foreach (q[i]) begin
            check("overrun page", q[i], exp[i]);
        end
        rd_seq(1'b0, 11'h000, 1, q);
        check("current address", q[0], exp[15]);
        $display("done page overrun");
    endtask

    task automatic test_top_wrap();
        logic [7:0] q[$];
        wr_seq(11'h7FF, '{8'hA5});
        wr_seq(11'h000, '{8'h5A});
        rd_seq(1'b1, 11'h7FF, 2, q);
        check("top byte", q[0], 8'hA5);
        check("array wrap", q[1], 8'h5A);
        $display("done array wrap");
    endtask

    task automatic test_protect();
        logic [7:0] q[$];
        writeProtect = 1'b1;
        wr_seq(11'h000, '{8'hC3});
        writeProtect = 1'b0;
        rd_seq(1'b1, 11'h000, 1, q);
        check("protected byte", q[0], 8'h5A);
        $display("done write protect");
    endtask

    task automatic test_mismatch();
        logic a;
        i_m.bus_start();
        i_m.send_byte(8'hB0, a);
        check("foreign address", {7'h0, a}, 8'h00);
        check("data pin value", {7'h0, sdaOut}, 8'h00);
        i_m.bus_stop();
        $display("done address mismatch");
    endtask

    initial begin
        num_errors   = 0;
        n_tests      = 0;
        sys_rst      = 1'b1;
        writeProtect = 1'b0;
        selPins      = 3'h0;
        repeat (4) @(posedge clock);
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge clock);
        #1;
        test_mismatch();
        test_page_wrap();
        test_overrun();
        test_top_wrap();
        test_protect();
        report_and_stop();
    end
endmodule // sea_eeprom_target_test

// ==== sea_fifo.sv ====
`timescale 1ns/10ps
module sea_fifo
    import sea_pkg::*;
#(
    parameter int WIDTH = 19,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
    end

    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign inReady  = count_r != (AW+1)'(DEPTH);
    assign outValid = count_r != '0;
    assign outData  = mem_r[rdPtr_r];

    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) wrPtr_r <= wrPtr_r + 1'b1;
            if (pop)  rdPtr_r <= rdPtr_r + 1'b1;
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // sea_fifo

// ==== sea_pkg.sv ====
package sea_pkg;
    localparam int SEA_BYTE_W       = 8;
    localparam int SEA_DEV_CODE_W   = 4;
    localparam logic [3:0] SEA_DEV_CODE = 4'hA;
    localparam int SEA_SEL_W        = 3;
    localparam int SEA_CLK_MHZ      = 100;
    localparam int SEA_PROG_MS      = 5;
    localparam int SEA_PROG_CYC     = SEA_PROG_MS * 1000 * 1000 * SEA_CLK_MHZ / 1000;
    localparam int SEA_BITS_PER_BYTE = 8;
    localparam logic [3:0] SEA_BIT_LAST = 4'h7;
    localparam logic [3:0] SEA_BIT_ACK  = 4'h8;
    localparam int SEA_FIFO_DEPTH   = 8;

    typedef struct packed {
        logic [10:0] addr;
        logic [7:0]  data;
    } sea_wr_t;
endpackage
